// *** logic/cict_pkg.sv ***
// Opcode classes, lengths and cycle counts for the instruction timing decoder
// Operation
// - Timing counted in system clocks only
// - Most instructions: cycles equal byte count
// - Untaken branch finishes one cycle sooner
// - Bank register ALU/move/exchange: 1 byte, 1
// - Accumulator with direct source: 2 bytes, 2
// - Indirect RAM operations: 1 byte, 2 cycles
// - Accumulator with immediate: 2 bytes, 2
// - Immediate into direct logic/move: 3, 3
// - Accumulator into direct logic/move: 2, 2
// - Accumulator-only operations: 1 byte, 1
// - Data pointer increment: 1 byte, 1
// - Direct to direct move: 3, 3
// - Data pointer immediate load: 3, 3
// - Code byte moves: 1 byte, 3 cycles
// - External data moves: 1 byte, 3 cycles
// - Indirect stores: 1/2 bytes, 2 cycles
// - Indirect-to-direct, direct/immediate-to-bank: 2, 2
// - Push and pop: 2 bytes, 2
// - Low nibble exchange: 1 byte, 2
// - Bit ops 2/2, carry ops 1/1
// - Relative offset signed, from next instruction
// - Unassigned opcode decodes as no-operation
package cict_pkg;
  localparam int OPC_W    = 8;
  localparam int LEN_W    = 2;
  localparam int CYC_W    = 4;
  localparam int PC_W     = 16;
  localparam logic [OPC_W-1:0] OPC_NOP   = 8'h00;
  localparam logic [OPC_W-1:0] OPC_SPARE = 8'ha5;
  localparam logic [CYC_W-1:0] CYC_ONE   = 4'h1;
  // Fallback timing for opcodes outside the covered classes
  localparam logic [LEN_W-1:0] LEN_DFLT  = 2'h1;
  localparam logic [CYC_W-1:0] CYC_DFLT  = 4'h1;
endpackage : cict_pkg

// *** logic/cict_issue_if.sv ***
// Decoded timing bundle passed from the decoder to the issue sequencer
interface cict_issue_if;
  logic [cict_pkg::LEN_W-1:0] len;
  logic [cict_pkg::CYC_W-1:0] cycTaken;
  logic [cict_pkg::CYC_W-1:0] cycNotTaken;
  logic                       isBranch;
  logic                       isRel;
  logic                       known;
  modport dec (output len, cycTaken, cycNotTaken, isBranch, isRel, known);
  modport seq (input  len, cycTaken, cycNotTaken, isBranch, isRel, known);
endinterface : cict_issue_if

// *** logic/cict_decode.sv ***
// Combinational opcode to length and cycle-count table
module cict_decode
(
  input  wire logic [cict_pkg::OPC_W-1:0] opcode,
  cict_issue_if.dec                       tim
);
  logic [3:0] hi;
  logic [3:0] lo;
  logic [cict_pkg::LEN_W-1:0] l;
  logic [cict_pkg::CYC_W-1:0] c;
  logic [cict_pkg::CYC_W-1:0] cn;
  logic br;
  logic rl;
  logic kn;

  assign hi = opcode[7:4];
  assign lo = opcode[3:0];

  always_comb
  begin
    l  = cict_pkg::LEN_DFLT;
    c  = cict_pkg::CYC_DFLT;
    cn = cict_pkg::CYC_DFLT;
    br = 1'b0;
    rl = 1'b0;
    kn = 1'b1;
    // bank register forms of ALU, inc, dec, move, exchange
    if (lo >= 4'h8 && (hi == 4'h0 || hi == 4'h1 || hi == 4'h2 ||
        hi == 4'h3 || hi == 4'h4 || hi == 4'h5 || hi == 4'h6 ||
        hi == 4'h9 || hi == 4'hc || hi == 4'he || hi == 4'hf))
    begin
      l = 2'h1; c = 4'h1;
    end
    // direct or immediate into bank register
    else if (lo >= 4'h8 && (hi == 4'h7 || hi == 4'ha))
    begin
      l = 2'h2; c = 4'h2;
    end
    else if (lo >= 4'h8 && hi == 4'h8)
    begin
      l = 2'h2; c = 4'h2;
    end
    else if (lo >= 4'h8 && hi == 4'hd)
    begin
      // decrement-and-branch: taken 3, not taken 2
      l = 2'h2; c = 4'h3; cn = 4'h2; br = 1'b1; rl = 1'b1;
    end
    else if (lo >= 4'h8 && hi == 4'hb)
    begin
      l = 2'h3; c = 4'h4; cn = 4'h3; br = 1'b1; rl = 1'b1;
    end
    // indirect RAM arithmetic, logic, inc, dec, move, exchange
    else if ((lo == 4'h6 || lo == 4'h7) && (hi == 4'h0 || hi == 4'h1 ||
        hi == 4'h2 || hi == 4'h3 || hi == 4'h4 || hi == 4'h5 ||
        hi == 4'h6 || hi == 4'h9 || hi == 4'hc || hi == 4'he))
    begin
      l = 2'h1; c = 4'h2;
    end
    else if ((lo == 4'h6 || lo == 4'h7) && hi == 4'hd)
    begin
      l = 2'h1; c = 4'h2;
    end
    else if ((lo == 4'h6 || lo == 4'h7) && hi == 4'hf)
    begin
      l = 2'h1; c = 4'h2;
    end
    // direct or immediate through indirect pointer
    else if ((lo == 4'h6 || lo == 4'h7) && (hi == 4'h7 || hi == 4'ha))
    begin
      l = 2'h2; c = 4'h2;
    end
    else if ((lo == 4'h6 || lo == 4'h7) && hi == 4'h8)
    begin
      l = 2'h2; c = 4'h2;
    end
    else if ((lo == 4'h6 || lo == 4'h7) && hi == 4'hb)
    begin
      l = 2'h3; c = 4'h5; cn = 4'h4; br = 1'b1; rl = 1'b1;
    end
    else
    begin
      unique case (opcode)
        8'h25, 8'h35, 8'h95, 8'h55, 8'h45, 8'h65, 8'he5, 8'hc5,
        8'h05, 8'h15, 8'hf5:
        begin
          l = 2'h2; c = 4'h2;
        end
        8'hc0, 8'hd0:
        begin
          l = 2'h2;
          c = 4'h2;
        end
        8'h24, 8'h34, 8'h94, 8'h54, 8'h44, 8'h64, 8'h74:
        begin
          l = 2'h2; c = 4'h2;
        end
        8'h52, 8'h42, 8'h62:
        begin
          l = 2'h2; c = 4'h2;
        end
        8'h53, 8'h43, 8'h63, 8'h75:
        begin
          l = 2'h3; c = 4'h3;
        end
        // direct to direct; data pointer load
        8'h85, 8'h90:
        begin
          l = 2'h3; c = 4'h3;
        end
        8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4, 8'hd4,
        8'h04, 8'h14, 8'ha3, 8'hc3, 8'hd3, 8'hb3:
        begin
          l = 2'h1; c = 4'h1;
        end
        8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2,
        8'h92:
        begin
          l = 2'h2; c = 4'h2;
        end
        // code byte moves; external data moves
        8'h93, 8'h83, 8'he2, 8'he3, 8'hf2, 8'hf3, 8'he0, 8'hf0:
        begin
          l = 2'h1; c = 4'h3;
        end
        8'ha4:
        begin
          l = 2'h1; c = 4'h4;
        end
        8'h84:
        begin
          l = 2'h1; c = 4'h8;
        end
        // short conditional branches: taken 3, not taken 2
        8'h40, 8'h50, 8'h60, 8'h70:
        begin
          l = 2'h2; c = 4'h3; cn = 4'h2; br = 1'b1; rl = 1'b1;
        end
        8'h20, 8'h30, 8'h10, 8'hb4, 8'hd5:
        begin
          l = 2'h3; c = 4'h4; cn = 4'h3; br = 1'b1; rl = 1'b1;
        end
        8'hb5:
        begin
          l = 2'h3; c = 4'h5; cn = 4'h4; br = 1'b1; rl = 1'b1;
        end
        // spare opcode behaves as the defined no-operation
        cict_pkg::OPC_NOP, cict_pkg::OPC_SPARE:
        begin
          l = 2'h1; c = cict_pkg::CYC_ONE;
        end
        default:
        begin
          l  = cict_pkg::LEN_DFLT;
          c  = cict_pkg::CYC_DFLT;
          kn = 1'b0;
        end
      endcase
    end
    if (!br)
      cn = c;
  end

  assign tim.len         = l;
  assign tim.cycTaken    = c;
  assign tim.cycNotTaken = cn;
  assign tim.isBranch    = br;
  assign tim.isRel       = rl;
  assign tim.known       = kn;
endmodule : cict_decode

// *** logic/cict_timing.sv ***
// Issue sequencer: holds each instruction for its exact cycle count
module cict_timing
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       instrValid,
  input  wire logic [cict_pkg::OPC_W-1:0] opcode,
  input  wire logic [cict_pkg::PC_W-1:0]  pc,
  input  wire logic [7:0]                 relOffset,
  input  wire logic                       branchTaken,
  output logic                            instrReady,
  output logic                            done,
  output logic [cict_pkg::LEN_W-1:0]      lenOut,
  output logic [cict_pkg::CYC_W-1:0]      cycOut,
  output logic                            knownOut,
  output logic [cict_pkg::PC_W-1:0]       nextPc,
  output logic [cict_pkg::PC_W-1:0]       branchTarget
);
  typedef enum logic {ST_IDLE, ST_EXEC} cict_state_e;
  cict_state_e state_q;
  logic [cict_pkg::CYC_W-1:0] cnt_q;
  logic [cict_pkg::CYC_W-1:0] cycSel;
  logic [cict_pkg::PC_W-1:0]  nxt;
  logic take;
  cict_issue_if tim ();

  cict_decode u_dec
  (
    .opcode (opcode),
    .tim    (tim)
  );

  // untaken branch uses the shorter count
  assign cycSel = (tim.isBranch && !branchTaken) ? tim.cycNotTaken
                                                 : tim.cycTaken;
  // accept when idle or in the last cycle of the previous count
  assign instrReady = (state_q == ST_IDLE) ||
                      (cnt_q == cict_pkg::CYC_ONE);
  assign take = instrValid && instrReady;
  assign nxt  = pc + {{(cict_pkg::PC_W-cict_pkg::LEN_W){1'b0}}, tim.len};

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end
    else if (take)
    begin
      state_q <= ST_EXEC;
      cnt_q   <= cycSel;
    end
    else if (state_q == ST_EXEC && cnt_q == cict_pkg::CYC_ONE)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end
    else if (state_q == ST_EXEC)
      cnt_q <= cnt_q - cict_pkg::CYC_ONE;
  end

  assign done = (state_q == ST_EXEC) && (cnt_q == cict_pkg::CYC_ONE);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      lenOut       <= '0;
      cycOut       <= '0;
      knownOut     <= 1'b0;
      nextPc       <= '0;
      branchTarget <= '0;
    end
    else if (take)
    begin
      lenOut   <= tim.len;
      cycOut   <= cycSel;
      knownOut <= tim.known;
      nextPc   <= nxt;
      // signed offset added to next instruction address
      branchTarget <= tim.isRel
        ? nxt + {{(cict_pkg::PC_W-8){relOffset[7]}}, relOffset} : nxt;
    end
  end

  a_count_load: assert property (@(posedge clk_sys) disable iff (rst)
    take |=> cnt_q == $past(cycSel))
    else $error("count not loaded");
  // untaken is one shorter than taken
  a_untaken_short: assert property (@(posedge clk_sys) disable iff (rst)
    tim.isBranch |-> tim.cycNotTaken + 4'h1 == tim.cycTaken)
    else $error("untaken branch not one shorter");
  a_no_early: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_EXEC && cnt_q > cict_pkg::CYC_ONE) |-> !instrReady)
    else $error("issue before count elapsed");
  a_done_span: assert property (@(posedge clk_sys) disable iff (rst)
    (take && cycSel == 4'h2) |=> !done ##1 done)
    else $error("two cycle instruction mistimed");
  a_one_cycle: assert property (@(posedge clk_sys) disable iff (rst)
    (take && opcode == 8'h28) |=> done)
    else $error("bank add not one cycle");
  a_spare_nop: assert property (@(posedge clk_sys) disable iff (rst)
    (opcode == cict_pkg::OPC_SPARE) |-> tim.len == 2'h1 && tim.known)
    else $error("spare opcode not nop");
  a_ext_move_three: assert property (@(posedge clk_sys) disable iff (rst)
    (take && opcode == 8'he0) |=> !done ##1 !done ##1 done)
    else $error("external move not three cycles");
  a_rel_target: assert property (@(posedge clk_sys) disable iff (rst)
    (take && tim.isRel) |=> branchTarget ==
      nextPc + {{8{$past(relOffset[7])}}, $past(relOffset)})
    else $error("relative target wrong");
endmodule : cict_timing

// *** verification/cict_timing_tb.sv ***
// Self-checking bench for the instruction timing sequencer
module cict_timing_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef logic [7:0] cict_opq_t[$];
  logic                              clk_sys;
  logic                              rst;
  logic                              instrValid;
  logic [cict_pkg::OPC_W-1:0]        opcode;
  logic [cict_pkg::PC_W-1:0]         pc;
  logic [7:0]                        relOffset;
  logic                              branchTaken;
  logic                              instrReady;
  logic                              done;
  logic [cict_pkg::LEN_W-1:0]        lenOut;
  logic [cict_pkg::CYC_W-1:0]        cycOut;
  logic                              knownOut;
  logic [cict_pkg::PC_W-1:0]         nextPc;
  logic [cict_pkg::PC_W-1:0]         branchTarget;
  logic [15:0]                       pcVal;
  int                                badCount;
  int                                checks;

  cict_timing DUT
  (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .instrValid   (instrValid),
    .opcode       (opcode),
    .pc           (pc),
    .relOffset    (relOffset),
    .branchTaken  (branchTaken),
    .instrReady   (instrReady),
    .done         (done),
    .lenOut       (lenOut),
    .cycOut       (cycOut),
    .knownOut     (knownOut),
    .nextPc       (nextPc),
    .branchTarget (branchTarget)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic completeRun();
    if (badCount == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : completeRun

  task automatic chk(input string what, input logic [15:0] expv,
                     input logic [15:0] gotv);
    checks++;
    if (gotv !== expv)
    begin
      badCount++;
      $display("wrong value %s expected %h seen %h", what, expv, gotv);
    end
  endtask : chk

  // Entered at a falling edge with the sequencer ready; returns in the
  // done cycle so the next call issues back to back
  task automatic exec(input logic [7:0] opc, input logic [1:0] len,
                      input logic [3:0] cyc, input logic tkn,
                      input logic isRel, input logic [7:0] rel);
    logic [15:0] expNext;
    logic [15:0] expTgt;
    expNext = pcVal + 16'(len);
    expTgt = isRel ? expNext + {{8{rel[7]}}, rel} : expNext;
    instrValid = 1'b1;
    opcode = opc;
    pc = pcVal;
    relOffset = rel;
    branchTaken = tkn;
    chk("instrReady", 16'h0001, 16'(instrReady));
    @(posedge clk_sys);
    for (int k = 1; k <= int'(cyc); k++)
    begin
      @(negedge clk_sys);
      chk("done", 16'(k == int'(cyc)), 16'(done));
      chk("instrReady", 16'(k == int'(cyc)), 16'(instrReady));
      chk("lenOut", 16'(len), 16'(lenOut));
      chk("cycOut", 16'(cyc), 16'(cycOut));
      // A refused offer must not disturb the instruction in flight
      if (k == 1 && cyc > 4'h1)
      begin
        opcode = 8'h84;
        branchTaken = ~tkn;
      end
    end
    chk("knownOut", 16'h0001, 16'(knownOut));
    chk("nextPc", expNext, nextPc);
    chk("branchTarget", expTgt, branchTarget);
    pcVal = expNext;
  endtask : exec

  task automatic checkSet(input cict_opq_t ops, input logic [1:0] len,
                          input logic [3:0] cyc);
    foreach (ops[i])
      exec(ops[i], len, cyc, 1'b0, 1'b0, 8'h00);
  endtask : checkSet

  // Long jump row (02) falls outside the table and is flagged unknown, issuing as one byte in one cycle
  task automatic tUncovered();
    instrValid = 1'b1;
    opcode = 8'h02;
    pc = pcVal;
    chk("instrReady", 16'h0001, 16'(instrReady));
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("knownOut", 16'h0000, 16'(knownOut));
    chk("done", 16'h0001, 16'(done));
    chk("lenOut", 16'h0001, 16'(lenOut));
    chk("nextPc", pcVal + 16'h0001, nextPc);
    pcVal = pcVal + 16'h0001;
  endtask : tUncovered

  task automatic tFixed();
    checkSet('{8'h28, 8'h3b, 8'h9f, 8'h09, 8'h1a, 8'h58, 8'h48,
               8'h68, 8'he8, 8'hc8}, 2'h1, 4'h1);
    checkSet('{8'h25, 8'h35, 8'h95, 8'h55, 8'h45, 8'h65, 8'he5,
               8'hc5}, 2'h2, 4'h2);
    checkSet('{8'h26, 8'h37, 8'h96, 8'h56, 8'h47, 8'h66, 8'h06,
               8'h17, 8'he6, 8'hc7}, 2'h1, 4'h2);
    checkSet('{8'h24, 8'h34, 8'h94, 8'h54, 8'h44, 8'h64,
               8'h74}, 2'h2, 4'h2);
    checkSet('{8'h53, 8'h43, 8'h63, 8'h75}, 2'h3, 4'h3);
    checkSet('{8'h52, 8'h42, 8'h62, 8'hf5}, 2'h2, 4'h2);
    checkSet('{8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4,
               8'hd4, 8'h04, 8'h14}, 2'h1, 4'h1);
    checkSet('{8'ha3}, 2'h1, 4'h1);
    checkSet('{8'h85}, 2'h3, 4'h3);
    checkSet('{8'h90}, 2'h3, 4'h3);
    checkSet('{8'h93, 8'h83}, 2'h1, 4'h3);
    checkSet('{8'he2, 8'hf3, 8'he0, 8'hf0}, 2'h1, 4'h3);
    checkSet('{8'hf6}, 2'h1, 4'h2);
    checkSet('{8'ha6, 8'h76}, 2'h2, 4'h2);
    checkSet('{8'h86, 8'ha8, 8'h78}, 2'h2, 4'h2);
    checkSet('{8'hc0, 8'hd0}, 2'h2, 4'h2);
    checkSet('{8'hd6}, 2'h1, 4'h2);
    checkSet('{8'hc2, 8'hd2, 8'hb2}, 2'h2, 4'h2);
    checkSet('{8'hc3, 8'hd3, 8'hb3}, 2'h1, 4'h1);
    checkSet('{8'ha5, 8'h00}, 2'h1, 4'h1);
  endtask : tFixed

  task automatic tBranch();
    exec(8'h40, 2'h2, 4'h3, 1'b1, 1'b1, 8'hf0);
    exec(8'h40, 2'h2, 4'h2, 1'b0, 1'b1, 8'h7f);
    exec(8'h20, 2'h3, 4'h4, 1'b1, 1'b1, 8'h80);
    exec(8'h20, 2'h3, 4'h3, 1'b0, 1'b1, 8'h01);
    exec(8'hb5, 2'h3, 4'h5, 1'b1, 1'b1, 8'hfe);
    exec(8'hb5, 2'h3, 4'h4, 1'b0, 1'b1, 8'h10);
  endtask : tBranch

  // Reset in the middle of a three-cycle transfer abandons it
  task automatic tReset();
    instrValid = 1'b1;
    opcode = 8'he0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b1;
    instrValid = 1'b0;
    @(negedge clk_sys);
    rst = 1'b0;
    chk("done", 16'h0000, 16'(done));
    chk("instrReady", 16'h0001, 16'(instrReady));
    chk("cycOut", 16'h0000, 16'(cycOut));
    @(negedge clk_sys);
    exec(8'h84, 2'h1, 4'h8, 1'b0, 1'b0, 8'h00);
  endtask : tReset

  initial
  begin
    rst = 1'b1;
    instrValid = 1'b0;
    opcode = 8'h00;
    pc = 16'h0000;
    relOffset = 8'h00;
    branchTaken = 1'b0;
    pcVal = 16'hfff8;
    badCount = 0;
    checks = 0;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    tFixed();
    tBranch();
    tUncovered();
    tReset();
    completeRun();
  end

  // Whole run needs under two hundred cycles; this margin only catches hangs
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    badCount++;
    completeRun();
  end
endmodule : cict_timing_tb
